// [shared/bwc_regs.vh]
// Register offsets, field positions, masks and load values of the
// bus and wake control group; assumes 7-bit SPI addresses.
`ifndef BWC_REGS_VH
`define BWC_REGS_VH

// Register addresses
`define BWC_ADDR_BUS        7'h04
`define BWC_ADDR_PEAK       7'h05
`define BWC_ADDR_INTWAKE    7'h06
`define BWC_ADDR_EXTWAKE    7'h07

// Reset values
`define BWC_RST_BUS         8'h20
`define BWC_RST_PEAK        8'h00
`define BWC_RST_INTWAKE     8'h00
`define BWC_RST_EXTWAKE     8'h07

// Implemented bits; every other position is reserved
`define BWC_MASK_BUS        8'hfb
`define BWC_MASK_PEAK       8'h20
`define BWC_MASK_INTWAKE    8'hc4
`define BWC_MASK_EXTWAKE    8'ha7

// Bits kept on restart
`define BWC_KEEP_BUS        8'he0
`define BWC_KEEP_PEAK       8'h20
`define BWC_KEEP_INTWAKE    8'hc0
`define BWC_KEEP_EXTWAKE    8'ha7

// Fail-safe load: value of the forced bits, and which bits are kept
`define BWC_FS_BUS          8'h09
`define BWC_FS_KEEP_BUS     8'he0
`define BWC_FS_EXTWAKE      8'h07
`define BWC_FS_KEEP_EXTWAKE 8'h80

// Bus transceiver control fields
`define BWC_BIT_LIN_FLASH   7
`define BWC_BIT_LIN_SLOW    6
`define BWC_BIT_LIN_TIMEOUT 5
`define BWC_LIN_MODE_HI     4
`define BWC_LIN_MODE_LO     3
`define BWC_CAN_MODE_HI     1
`define BWC_CAN_MODE_LO     0

// Other single-bit fields
`define BWC_BIT_PEAK        5
`define BWC_BIT_TIMER2_WAKE 7
`define BWC_BIT_TIMER1_WAKE 6
`define BWC_BIT_WD_STOP_HI  2
`define BWC_BIT_INT_GLOBAL  7
`define BWC_BIT_MEASURE     5
`define BWC_BIT_WAKE_C      2
`define BWC_BIT_WAKE_B      1
`define BWC_BIT_WAKE_A      0

// Transceiver mode codes
`define BWC_XCVR_OFF        2'h0
`define BWC_XCVR_WAKE       2'h1
`define BWC_XCVR_RXONLY     2'h2
`define BWC_XCVR_NORMAL     2'h3

// Chip operating mode codes seen on sbcMode
`define BWC_SBC_INIT        2'h0
`define BWC_SBC_NORMAL      2'h1
`define BWC_SBC_STOP        2'h2
`define BWC_SBC_OTHER       2'h3

// SPI frame
`define BWC_FRAME_BITS      5'h10
`define BWC_HEADER_BITS     5'h08
`define BWC_BIT_WRITE       7

`endif

// [src/bwc_edge_detect.v]
// Rise and fall pulses of a group of synchronous inputs.
// Assumes the inputs are already synchronous to clock.
module bwc_edge_detect #(
  parameter WIDTH = 2
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire [WIDTH-1:0] level,
  input  wire [WIDTH-1:0] idleLevel,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] levelPrev_r;

  // Previous level starts at zero; idleLevel masks a false edge at release
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      levelPrev_r <= {WIDTH{1'b0}};
    else
      levelPrev_r <= level;
  end

  assign rise = level & ~levelPrev_r & ~idleLevel;
  assign fall = ~level & levelPrev_r;

endmodule

// [src/bwc_spi_shift.v]
// Serial-in shift register with bit counter for one SPI frame.
// Assumes LSB-first data sampled on the strobe; counter saturates.
module bwc_spi_shift #(
  parameter WIDTH = 16
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire             frameStart,
  input  wire             sampleStrobe,
  input  wire             serialIn,
  output reg  [WIDTH-1:0] shiftData_r,
  output reg  [4:0]       bitCount_r
);

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      shiftData_r <= {WIDTH{1'b0}};
      bitCount_r  <= 5'h00;
    end
    else if (frameStart)
    begin
      shiftData_r <= {WIDTH{1'b0}};
      bitCount_r  <= 5'h00;
    end
    else if (sampleStrobe)
    begin
      shiftData_r <= {serialIn, shiftData_r[WIDTH-1:1]};
      // Saturation keeps an overlong frame detectable
      if (bitCount_r != 5'h1f)
        bitCount_r <= bitCount_r + 5'h01;
    end
  end

endmodule

// [src/bwc_top.v]
// Bus transceiver and wake control registers behind a 16-bit SPI slave.
// Assumes SPI pins synchronous to clock, mode 0, LSB first, and that
// chip mode, restart and fail-safe events come from the state machine.
`include "bwc_regs.vh"

module bwc_top (
  input  wire       clock,
  input  wire       resetn,
  input  wire       chipSelectLowActiveN,
  input  wire       spiClk,
  input  wire       spiMosi,
  output wire       spiMiso,
  output wire       spiMisoOe,
  input  wire [1:0] sbcMode,
  input  wire       restartEvent,
  input  wire [1:0] restartLinMode,
  input  wire [1:0] restartCanMode,
  input  wire       failSafeEvent,
  input  wire       hwLinModeLoad,
  input  wire [1:0] hwLinModeValue,
  input  wire       hwCanModeLoad,
  input  wire [1:0] hwCanModeValue,
  input  wire       hwWdStopLoad,
  input  wire       hwWdStopValue,
  input  wire       watchdogStopDisableLo,
  output wire       linFlashMode,
  output wire       linSlowSlopeSelect,
  output wire       linTransmitTimeoutEnable,
  output wire [1:0] linTransceiverMode,
  output wire [1:0] canTransceiverMode,
  output wire       regulatorPeakThreshold,
  output wire       secondTimerWakeEnable,
  output wire       firstTimerWakeEnable,
  output wire       watchdogStopDisableHi,
  output wire       interruptGlobalScope,
  output wire       wakeOrMeasureSelect,
  output wire [2:0] wakeInputEnable,
  output wire       measureActive,
  output wire       wakeLevelIgnore,
  output wire       watchdogStopInactive,
  output wire       spiFrameError
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function [7:0] bwcMerge;
    input [7:0] oldValue;
    input [7:0] newValue;
    input [7:0] mask;
    begin
      bwcMerge = (oldValue & ~mask) | (newValue & mask);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]  busReg_r;
  reg  [7:0]  busReg_nxt;
  reg  [7:0]  peakReg_r;
  reg  [7:0]  peakReg_nxt;
  reg  [7:0]  intWakeReg_r;
  reg  [7:0]  intWakeReg_nxt;
  reg  [7:0]  extWakeReg_r;
  reg  [7:0]  extWakeReg_nxt;
  reg  [7:0]  readValue;
  reg  [7:0]  txShift_r;
  reg         miso_r;
  reg         misoOe_r;
  reg         headerPending_r;
  reg  [2:0]  wakeEn_r;
  reg         measureActive_r;
  reg         wdStopInactive_r;
  reg         frameError_r;
  wire        csActive;
  wire [1:0]  pinRise;
  wire [1:0]  pinFall;
  wire        clkRise;
  wire        csFall;
  wire        csRise;
  wire [15:0] shiftData;
  wire [4:0]  bitCount;
  wire [6:0]  frameAddr;
  wire        frameWrite;
  wire [7:0]  frameData;
  wire        frameDone;
  wire        writeStrobe;
  wire        inStop;

  assign csActive = ~chipSelectLowActiveN;

  ////////////////////////////////////////////////////////////////////////
  // SPI front end

  bwc_edge_detect #(
    .WIDTH (2)
  ) u_edge (
    .clock     (clock),
    .resetn    (resetn),
    .level     ({csActive, spiClk}),
    .idleLevel (2'h0),
    .rise      (pinRise),
    .fall      (pinFall)
  );

  assign clkRise = pinRise[0] & csActive;
  assign csFall  = pinRise[1];
  assign csRise  = pinFall[1];

  bwc_spi_shift #(
    .WIDTH (16)
  ) u_shift (
    .clock        (clock),
    .resetn       (resetn),
    .frameStart   (csFall),
    .sampleStrobe (clkRise),
    .serialIn     (spiMosi),
    .shiftData_r  (shiftData),
    .bitCount_r   (bitCount)
  );

  assign frameAddr  = shiftData[6:0];
  assign frameWrite = shiftData[`BWC_BIT_WRITE];
  assign frameData  = shiftData[15:8];
  // Only an exact 16-bit frame commits; the write lands as select rises
  assign frameDone   = csRise & (bitCount == `BWC_FRAME_BITS);
  assign writeStrobe = frameDone & frameWrite;
  assign inStop      = (sbcMode == `BWC_SBC_STOP);

  ////////////////////////////////////////////////////////////////////////
  // Readback

  always @*
  begin
    readValue = 8'h00;
    case (shiftData[14:8])
      `BWC_ADDR_BUS:     readValue = busReg_r & `BWC_MASK_BUS;
      `BWC_ADDR_PEAK:    readValue = peakReg_r & `BWC_MASK_PEAK;
      `BWC_ADDR_INTWAKE: readValue = intWakeReg_r & `BWC_MASK_INTWAKE;
      `BWC_ADDR_EXTWAKE: readValue = extWakeReg_r & `BWC_MASK_EXTWAKE;
      default:           readValue = 8'h00;
    endcase
  end

  // Header byte sits in shiftData[15:8] right after the eighth bit
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      headerPending_r <= 1'b0;
      txShift_r       <= 8'h00;
      miso_r          <= 1'b0;
      misoOe_r        <= 1'b0;
    end
    else
    begin
      misoOe_r        <= csActive;
      headerPending_r <= clkRise & (bitCount == `BWC_HEADER_BITS - 5'h01);
      if (csFall)
      begin
        txShift_r <= 8'h00;
        miso_r    <= 1'b0;
      end
      else if (headerPending_r)
        txShift_r <= readValue;
      else if (pinFall[0] & csActive & (bitCount >= `BWC_HEADER_BITS))
      begin
        miso_r    <= txShift_r[0];
        txShift_r <= {1'b0, txShift_r[7:1]};
      end
      else if (!csActive)
        miso_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values; fail-safe over restart over hardware over SPI

  always @*
  begin
    busReg_nxt = busReg_r;
    if (writeStrobe && (frameAddr == `BWC_ADDR_BUS))
      busReg_nxt = bwcMerge(busReg_r, frameData, `BWC_MASK_BUS);
    if (hwLinModeLoad)
      busReg_nxt[`BWC_LIN_MODE_HI:`BWC_LIN_MODE_LO] = hwLinModeValue;
    if (hwCanModeLoad)
      busReg_nxt[`BWC_CAN_MODE_HI:`BWC_CAN_MODE_LO] = hwCanModeValue;
    if (restartEvent)
      busReg_nxt = (busReg_r & `BWC_KEEP_BUS)
                   | {3'h0, restartLinMode, 1'b0, restartCanMode};
    if (failSafeEvent)
      busReg_nxt = (busReg_r & `BWC_FS_KEEP_BUS) | `BWC_FS_BUS;
  end

  always @*
  begin
    peakReg_nxt = peakReg_r;
    // Stop mode drops the write without raising any error
    if (writeStrobe && (frameAddr == `BWC_ADDR_PEAK) && !inStop)
      peakReg_nxt = bwcMerge(peakReg_r, frameData, `BWC_MASK_PEAK);
    if (restartEvent)
      peakReg_nxt = peakReg_r & `BWC_KEEP_PEAK;
  end

  always @*
  begin
    intWakeReg_nxt = intWakeReg_r;
    if (writeStrobe && (frameAddr == `BWC_ADDR_INTWAKE))
      intWakeReg_nxt = bwcMerge(intWakeReg_r, frameData, `BWC_MASK_INTWAKE);
    if (hwWdStopLoad)
      intWakeReg_nxt[`BWC_BIT_WD_STOP_HI] = hwWdStopValue;
    if (restartEvent)
      intWakeReg_nxt = intWakeReg_r & `BWC_KEEP_INTWAKE;
  end

  always @*
  begin
    extWakeReg_nxt = extWakeReg_r;
    if (writeStrobe && (frameAddr == `BWC_ADDR_EXTWAKE))
      extWakeReg_nxt = bwcMerge(extWakeReg_r, frameData, `BWC_MASK_EXTWAKE);
    if (restartEvent)
      extWakeReg_nxt = extWakeReg_r & `BWC_KEEP_EXTWAKE;
    if (failSafeEvent)
      extWakeReg_nxt = (extWakeReg_r & `BWC_FS_KEEP_EXTWAKE) | `BWC_FS_EXTWAKE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage and derived controls

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      busReg_r         <= `BWC_RST_BUS;
      peakReg_r        <= `BWC_RST_PEAK;
      intWakeReg_r     <= `BWC_RST_INTWAKE;
      extWakeReg_r     <= `BWC_RST_EXTWAKE;
      wakeEn_r         <= 3'h0;
      measureActive_r  <= 1'b0;
      wdStopInactive_r <= 1'b0;
      frameError_r     <= 1'b0;
    end
    else
    begin
      busReg_r     <= busReg_nxt & `BWC_MASK_BUS;
      peakReg_r    <= peakReg_nxt & `BWC_MASK_PEAK;
      intWakeReg_r <= intWakeReg_nxt & `BWC_MASK_INTWAKE;
      extWakeReg_r <= extWakeReg_nxt & `BWC_MASK_EXTWAKE;
      // Measurement masks wake inputs a and b, enable bits stay stored
      wakeEn_r[2] <= extWakeReg_r[`BWC_BIT_WAKE_C];
      wakeEn_r[1] <= extWakeReg_r[`BWC_BIT_WAKE_B] & ~extWakeReg_r[`BWC_BIT_MEASURE];
      wakeEn_r[0] <= extWakeReg_r[`BWC_BIT_WAKE_A] & ~extWakeReg_r[`BWC_BIT_MEASURE];
      measureActive_r <= extWakeReg_r[`BWC_BIT_MEASURE]
                         & (sbcMode == `BWC_SBC_NORMAL);
      // Both halves set deactivate the watchdog in stop mode
      wdStopInactive_r <= intWakeReg_r[`BWC_BIT_WD_STOP_HI]
                          & watchdogStopDisableLo;
      // Short or long frames are dropped and flagged for one cycle
      frameError_r <= csRise & (bitCount != `BWC_FRAME_BITS);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign spiMiso                  = miso_r;
  assign spiMisoOe                = misoOe_r;
  assign linFlashMode             = busReg_r[`BWC_BIT_LIN_FLASH];
  assign linSlowSlopeSelect       = busReg_r[`BWC_BIT_LIN_SLOW];
  assign linTransmitTimeoutEnable = busReg_r[`BWC_BIT_LIN_TIMEOUT];
  assign linTransceiverMode       = busReg_r[`BWC_LIN_MODE_HI:`BWC_LIN_MODE_LO];
  assign canTransceiverMode       = busReg_r[`BWC_CAN_MODE_HI:`BWC_CAN_MODE_LO];
  assign regulatorPeakThreshold   = peakReg_r[`BWC_BIT_PEAK];
  assign secondTimerWakeEnable    = intWakeReg_r[`BWC_BIT_TIMER2_WAKE];
  assign firstTimerWakeEnable     = intWakeReg_r[`BWC_BIT_TIMER1_WAKE];
  assign watchdogStopDisableHi    = intWakeReg_r[`BWC_BIT_WD_STOP_HI];
  assign interruptGlobalScope     = extWakeReg_r[`BWC_BIT_INT_GLOBAL];
  assign wakeOrMeasureSelect      = extWakeReg_r[`BWC_BIT_MEASURE];
  assign wakeInputEnable          = wakeEn_r;
  assign measureActive            = measureActive_r;
  // Level status of inputs a and b is meaningless while measuring
  assign wakeLevelIgnore          = extWakeReg_r[`BWC_BIT_MEASURE];
  assign watchdogStopInactive     = wdStopInactive_r;
  assign spiFrameError            = frameError_r;

endmodule

// [testbench/bwc_spi_host.sv]
// Host model: SPI master sending one LSB-first frame per call.
// Assumes the bench clock; pins change only just after its edges.
module bwc_spi_host (
  input  wire logic clock,
  input  wire logic spiMiso,
  output logic      chipSelectLowActiveN,
  output logic      spiClk,
  output logic      spiMosi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    chipSelectLowActiveN = 1'b1;
    spiClk = 1'b0;
    spiMosi = 1'b0;
  end
  // Phases of three clocks, one above the minimum, for margin
  task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
    int b;
    rd = 8'h00;
    @(posedge clock);
    chipSelectLowActiveN <= 1'b0;
    for (b = 0; b < n; b++)
    begin
      spiMosi <= f[b];
      repeat (3) @(posedge clock);
      if (b >= 8)
        rd[b-8] = spiMiso;
      spiClk <= 1'b1;
      repeat (3) @(posedge clock);
      spiClk <= 1'b0;
    end
    repeat (3) @(posedge clock);
    chipSelectLowActiveN <= 1'b1;
    spiMosi <= ~spiMosi;  // Released line must not keep its value
    repeat (3) @(posedge clock);
  endtask
endmodule

// [testbench/bwc_top_asserts.sv]
// Checker for the bus and wake control registers, on top ports only.
// Assumes one clock domain and the async active-low reset.
`include "bwc_regs.vh"

module bwc_top_asserts (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [1:0] sbcMode,
  input wire logic       restartEvent,
  input wire logic [1:0] restartLinMode,
  input wire logic [1:0] restartCanMode,
  input wire logic       failSafeEvent,
  input wire logic       hwLinModeLoad,
  input wire logic [1:0] hwLinModeValue,
  input wire logic       hwCanModeLoad,
  input wire logic [1:0] hwCanModeValue,
  input wire logic       watchdogStopDisableLo,
  input wire logic       linFlashMode,
  input wire logic       linSlowSlopeSelect,
  input wire logic       linTransmitTimeoutEnable,
  input wire logic [1:0] linTransceiverMode,
  input wire logic [1:0] canTransceiverMode,
  input wire logic       regulatorPeakThreshold,
  input wire logic       secondTimerWakeEnable,
  input wire logic       firstTimerWakeEnable,
  input wire logic       watchdogStopDisableHi,
  input wire logic       interruptGlobalScope,
  input wire logic       wakeOrMeasureSelect,
  input wire logic [2:0] wakeInputEnable,
  input wire logic       measureActive,
  input wire logic       wakeLevelIgnore,
  input wire logic       watchdogStopInactive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_meas_gates_ab: assert property ($past(wakeOrMeasureSelect) |-> wakeInputEnable[1:0] == 2'b00)
    else $error("wake inputs a b enabled while measuring");
  a_level_ignore: assert property (wakeLevelIgnore == wakeOrMeasureSelect)
    else $error("level ignore differs from measure select");
  a_measure_normal: assert property (measureActive == $past(wakeOrMeasureSelect && sbcMode == `BWC_SBC_NORMAL))
    else $error("measurement active outside normal mode");
  a_wd_inactive: assert property (watchdogStopInactive == $past(watchdogStopDisableHi & watchdogStopDisableLo))
    else $error("watchdog stop state wrong");
  a_peak_stop: assert property (sbcMode == `BWC_SBC_STOP |=> $stable(regulatorPeakThreshold))
    else $error("peak threshold changed in stop");
  a_fs_wake_load: assert property (failSafeEvent |=> (linTransceiverMode == `BWC_XCVR_WAKE
    && canTransceiverMode == `BWC_XCVR_WAKE && !wakeOrMeasureSelect) ##1 wakeInputEnable == 3'b111)
    else $error("fail-safe load wrong");
  a_fs_keeps_opts: assert property (failSafeEvent |=> $stable({linFlashMode, linSlowSlopeSelect,
    linTransmitTimeoutEnable, interruptGlobalScope}))
    else $error("fail-safe lost kept bits");
  a_restart_modes: assert property (restartEvent && !failSafeEvent |=> linTransceiverMode == $past(restartLinMode)
    && canTransceiverMode == $past(restartCanMode) && !watchdogStopDisableHi)
    else $error("restart modes wrong");
  a_restart_keeps: assert property (restartEvent && !failSafeEvent |=> $stable({linFlashMode, linSlowSlopeSelect,
    linTransmitTimeoutEnable, regulatorPeakThreshold, secondTimerWakeEnable, firstTimerWakeEnable,
    interruptGlobalScope, wakeOrMeasureSelect}))
    else $error("restart changed kept bits");
  a_hw_lin_load: assert property (hwLinModeLoad && !restartEvent && !failSafeEvent
    |=> linTransceiverMode == $past(hwLinModeValue))
    else $error("lin mode hardware load lost");
  a_hw_can_load: assert property (hwCanModeLoad && !restartEvent && !failSafeEvent
    |=> canTransceiverMode == $past(hwCanModeValue))
    else $error("can mode hardware load lost");
endmodule

// [testbench/bwc_top_tb_top.sv]
// Self-checking bench for the bus and wake control registers.
// Assumes the host model and checker files of this folder.
`include "bwc_regs.vh"

module bwc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, resetn, chipSelectLowActiveN, spiClk, spiMosi, spiMiso, spiMisoOe;
  logic [1:0]  sbcMode, restartLinMode, restartCanMode, hwLinModeValue, hwCanModeValue;
  logic        restartEvent, failSafeEvent, hwLinModeLoad, hwCanModeLoad, hwWdStopLoad;
  logic        hwWdStopValue, watchdogStopDisableLo, spiFrameError, linFlashMode;
  logic        linSlowSlopeSelect, linTransmitTimeoutEnable, regulatorPeakThreshold;
  logic [1:0]  linTransceiverMode, canTransceiverMode;
  logic        secondTimerWakeEnable, firstTimerWakeEnable, watchdogStopDisableHi;
  logic        interruptGlobalScope, wakeOrMeasureSelect, measureActive, wakeLevelIgnore;
  logic        watchdogStopInactive;
  logic [2:0]  wakeInputEnable;
  logic [7:0]  m [4:7];
  logic [7:0]  mask [4:7];
  logic [7:0]  rd;
  logic [31:0] r;
  int          error_cnt, num_checks, seed, errPulses, i;
  wire  [18:0] outs = {linFlashMode, linSlowSlopeSelect, linTransmitTimeoutEnable,
    linTransceiverMode, canTransceiverMode, regulatorPeakThreshold, secondTimerWakeEnable,
    firstTimerWakeEnable, watchdogStopDisableHi, interruptGlobalScope, wakeOrMeasureSelect,
    wakeInputEnable, measureActive, wakeLevelIgnore, watchdogStopInactive};

  bwc_top i_bwc_top (.*);
  bwc_spi_host i_bwc_spi_host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
    if (spiFrameError === 1'b1)
      errPulses++;
  function automatic logic [18:0] expo();
    logic s;
    s = m[7][5];
    return {m[4][7:3], m[4][1:0], m[5][5], m[6][7:6], m[6][2], m[7][7], s, m[7][2],
      m[7][1] & ~s, m[7][0] & ~s, s && sbcMode == `BWC_SBC_NORMAL, s, m[6][2] & watchdogStopDisableLo};
  endfunction
  task automatic cmp_out();
    num_checks++;
    if (outs !== expo())
    begin
      error_cnt++;
      $display("Error at %0t: outputs %h expected %h", $time, outs, expo());
    end
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  // Read data shows the value held before this frame's write
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
    logic       hit;
    logic [7:0] prev;
    hit = a >= 7'h04 && a <= 7'h07;
    prev = hit ? m[a] : 8'h00;
    i_bwc_spi_host.xfer({d, w, a}, n, rd);
    if (n == 16)
      cmp_val(rd, prev);
    if (n == 16 && w && hit && !(a == 7'h05 && sbcMode == `BWC_SBC_STOP))
      m[a] = d & mask[a];
    cmp_out();
  endtask
  // k bits: restart, fail-safe, lin load, can load, watchdog bit load
  task automatic pulse(input logic [4:0] k, input logic [1:0] v);
    @(posedge clock);
    {restartEvent, failSafeEvent, hwLinModeLoad, hwCanModeLoad, hwWdStopLoad} <= k;
    {restartLinMode, restartCanMode, hwLinModeValue, hwCanModeValue} <= {v, ~v, v, ~v};
    hwWdStopValue <= v[0];
    @(posedge clock);
    {restartEvent, failSafeEvent, hwLinModeLoad, hwCanModeLoad, hwWdStopLoad} <= 5'h00;
    if (k[4])
    begin
      m[4] = m[4] & 8'he0 | {3'b000, v, 1'b0, ~v};
      m[6] = m[6] & 8'hc0;
    end
    else
    begin
      if (k[2]) m[4][4:3] = v;
      if (k[1]) m[4][1:0] = ~v;
      if (k[0]) m[6][2] = v[0];
    end
    if (k[3])
    begin
      m[4] = m[4] & 8'he0 | 8'h09;
      m[7] = m[7] & 8'h80 | 8'h07;
    end
    repeat (3) @(posedge clock);
    cmp_out();
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 29;
    {resetn, sbcMode, restartLinMode, restartCanMode, hwLinModeValue, hwCanModeValue} = 0;
    {restartEvent, failSafeEvent, hwLinModeLoad, hwCanModeLoad, hwWdStopLoad} = 5'h00;
    {hwWdStopValue, watchdogStopDisableLo} = 2'b00;
    {mask[4], mask[5], mask[6], mask[7]} = 32'hfb20c4a7;
    {m[4], m[5], m[6], m[7]} = 32'h20000007;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (i = 4; i < 8; i++)
      frame(i[6:0], 1'b0, 8'h00, 16);
    frame(7'h11, 1'b1, 8'hff, 16);
    frame(7'h11, 1'b0, 8'h00, 16);
    for (i = 0; i < 4; i++)
      frame(7'h04, 1'b1, {r[7:5], i[1:0], 1'b1, i[1:0]}, 16);
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      @(posedge clock);
      sbcMode <= r[9] ? `BWC_SBC_STOP : {1'b0, r[8]};
      watchdogStopDisableLo <= r[10];
      frame(7'h04 + r[17:16], 1'b1, r[7:0], 16);
    end
    @(posedge clock);
    sbcMode <= `BWC_SBC_STOP;
    frame(7'h05, 1'b1, ~m[5], 16);
    cmp_val(errPulses[7:0], 8'h00);
    frame(7'h04, 1'b1, 8'h00, 12);
    cmp_val(errPulses[7:0], 8'h01);
    @(posedge clock);
    sbcMode <= `BWC_SBC_NORMAL;
    frame(7'h07, 1'b1, 8'hff, 16);
    for (i = 0; i < 16; i++)
    begin
      r = $random(seed);
      @(posedge clock);
      watchdogStopDisableLo <= 1'b1;
      pulse(r[3] ? 5'h08 : r[4:0], r[6:5]);
      frame(7'h07, 1'b1, r[15:8], 16);
    end
    frame(7'h05, 1'b1, 8'hff, 16);
    frame(7'h06, 1'b0, 8'h00, 16);
    stop_test();
  end
endmodule

bind bwc_top bwc_top_asserts i_bwc_top_asserts (.*);
